// >>> hpbc_pkg.sv
// shared constants for the halt pin buffer control block
package hpbc_pkg;
    // -----------------------------------------------------------------
    // halt mode codes
    // -----------------------------------------------------------------
    localparam logic [1:0] MODE_NONE      = 2'h0;
    localparam logic [1:0] MODE_DEEP_STOP = 2'h1;
    localparam logic [1:0] MODE_OSC_ONLY  = 2'h2;
    localparam logic [1:0] MODE_CPU_ONLY  = 2'h3;

    // -----------------------------------------------------------------
    // warm-up select codes and source count exponents
    // -----------------------------------------------------------------
    localparam logic [1:0] WU_SEL_SHORT = 2'h1;
    localparam logic [1:0] WU_SEL_MID   = 2'h2;
    localparam logic [1:0] WU_SEL_LONG  = 2'h3;
    localparam int         WU_EXP_SHORT = 8;
    localparam int         WU_EXP_MID   = 14;
    localparam int         WU_EXP_LONG  = 16;
    localparam int         WU_CNT_W     = 17;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 10000;
    localparam int HS_SHORT_PS     = 7100000;
    localparam int HS_DIV_DEF      = (HS_SHORT_PS / (1 << WU_EXP_SHORT)
                                      + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int LS_SHORT_NS     = 7800000;
    localparam int LS_DIV_DEF      = (LS_SHORT_NS * 10 / (1 << WU_EXP_SHORT)
                                      + CLK_PERIOD_PS / 100 - 1)
                                     / (CLK_PERIOD_PS / 100);
    localparam int DIV_W           = 16;
    localparam int HALT_EXEC_STATES = 6;
    localparam int EXEC_W          = 3;

    // -----------------------------------------------------------------
    // controller states, gray along run, entry, halted, warm-up
    // -----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_RUN    = 2'h0,
        ST_ENTRY  = 2'h1,
        ST_HALTED = 2'h3,
        ST_WARMUP = 2'h2
    } hpbc_state_t;
endpackage : hpbc_pkg

// >>> hpbc_wu_if.sv
// warm-up request and answer between controller and timer
`timescale 1ns/100ps
`default_nettype none
interface hpbc_wu_if;
    logic       start;
    logic [1:0] sel;
    logic       slow;
    logic       busy;
    logic       done;
    modport ctrl  (output start, output sel, output slow,
                   input busy, input done);
    modport timer (input start, input sel, input slow,
                   output busy, output done);
endinterface : hpbc_wu_if
`default_nettype wire

// >>> hpbc_warmup.sv
// oscillator warm-up timer counting ticks of the chosen source clock
`timescale 1ns/100ps
`default_nettype none
module hpbc_warmup #(
    parameter int HS_DIV   = hpbc_pkg::HS_DIV_DEF,
    parameter int LS_DIV   = hpbc_pkg::LS_DIV_DEF,
    parameter int EXP_SHORT = hpbc_pkg::WU_EXP_SHORT,
    parameter int EXP_MID   = hpbc_pkg::WU_EXP_MID,
    parameter int EXP_LONG  = hpbc_pkg::WU_EXP_LONG
) (
    // clock and reset
    input wire logic   clock,
    input wire logic   arst_n,
    // request from controller
    hpbc_wu_if.timer   wu
);
    localparam int CW = hpbc_pkg::WU_CNT_W;
    localparam int DW = hpbc_pkg::DIV_W;

    logic [DW-1:0] div_cnt;
    logic [CW-1:0] src_cnt;
    logic [CW-1:0] limit;
    logic          slow_q;
    logic          tick;

    // -----------------------------------------------------------------
    // source tick divider
    // -----------------------------------------------------------------
    always_comb
    begin
        tick = slow_q ? (div_cnt == DW'(LS_DIV - 1))
                      : (div_cnt == DW'(HS_DIV - 1));
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            div_cnt <= '0;
        else if (wu.start || tick)
            div_cnt <= '0;
        else if (wu.busy)
            div_cnt <= div_cnt + DW'(1);
    end

    // -----------------------------------------------------------------
    // source count
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            limit  <= '0;
            slow_q <= 1'b0;
        end
        else if (wu.start)
        begin
            slow_q <= wu.slow;
            unique case (wu.sel)
                hpbc_pkg::WU_SEL_MID:  limit <= CW'(1) << EXP_MID;
                hpbc_pkg::WU_SEL_LONG: limit <= CW'(1) << EXP_LONG;
                default:               limit <= CW'(1) << EXP_SHORT;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            src_cnt <= '0;
            wu.busy <= 1'b0;
            wu.done <= 1'b0;
        end
        else
        begin
            wu.done <= 1'b0;
            if (wu.start)
            begin
                src_cnt <= '0;
                wu.busy <= 1'b1;
            end
            else if (wu.busy && tick)
            begin
                src_cnt <= src_cnt + CW'(1);
                if (src_cnt + CW'(1) == limit)
                begin
                    wu.busy <= 1'b0;
                    wu.done <= 1'b1;
                end
            end
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    wu_count_end_a: assert property (@(posedge clock) disable iff (!arst_n)
        wu.done |-> $past(src_cnt) + CW'(1) == limit)
        else $error("warm-up ended before full count");
    wu_tick_hs_a: assert property (@(posedge clock) disable iff (!arst_n)
        (wu.busy && !slow_q && !wu.start) |-> div_cnt < DW'(HS_DIV))
        else $error("high speed divider overran");
endmodule : hpbc_warmup
`default_nettype wire

// >>> halt_pin_buffer_control.sv
// halt sequencing, warm-up restart and pin buffer gating
`timescale 1ns/100ps
`default_nettype none
module halt_pin_buffer_control #(
    parameter int HS_DIV    = hpbc_pkg::HS_DIV_DEF,
    parameter int LS_DIV    = hpbc_pkg::LS_DIV_DEF,
    parameter int EXP_SHORT = hpbc_pkg::WU_EXP_SHORT,
    parameter int EXP_MID   = hpbc_pkg::WU_EXP_MID,
    parameter int EXP_LONG  = hpbc_pkg::WU_EXP_LONG
) (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // halt controller requests
    input  wire logic       halt_enter,
    input  wire logic [1:0] halt_mode,
    input  wire logic       halt_release,
    // configuration
    input  wire logic [1:0] warmup_sel,
    input  wire logic       restart_slow,
    input  wire logic       run_slow,
    input  wire logic       drive_ctrl,
    input  wire logic       drive_sel,
    // status
    output var  logic       cpu_clock_run,
    output var  logic       low_speed_active,
    output var  logic       halted,
    output var  logic       warmup_busy,
    // pin buffer control
    output var  logic       func_in_buf_en,
    output var  logic       func_out_buf_en,
    output var  logic       osc_in_buf_en,
    output var  logic       osc_out_drive_en,
    output var  logic       osc_out_force_high
);
    hpbc_pkg::hpbc_state_t state;
    hpbc_pkg::hpbc_state_t next_state;
    logic [1:0]                    mode_q;
    logic [hpbc_pkg::EXEC_W-1:0]   exec_cnt;
    logic                          restart_q;
    logic                          entry_end;
    logic                          light;
    logic                          deep;
    logic                          cond_b;
    logic                          unused_sel;

    hpbc_wu_if wu ();

    hpbc_warmup #(
        .HS_DIV    (HS_DIV),
        .LS_DIV    (LS_DIV),
        .EXP_SHORT (EXP_SHORT),
        .EXP_MID   (EXP_MID),
        .EXP_LONG  (EXP_LONG)
    ) u_warmup (
        .clock  (clock),
        .arst_n (arst_n),
        .wu     (wu.timer)
    );

    // -----------------------------------------------------------------
    // state sequencing
    // -----------------------------------------------------------------
    assign entry_end = exec_cnt == hpbc_pkg::EXEC_W'(
                       hpbc_pkg::HALT_EXEC_STATES - 1);

    always_comb
    begin
        next_state = state;
        unique case (state)
            hpbc_pkg::ST_RUN:
                if (halt_enter && halt_mode != hpbc_pkg::MODE_NONE)
                    next_state = hpbc_pkg::ST_ENTRY;
            hpbc_pkg::ST_ENTRY:
                if (halt_release)
                    next_state = hpbc_pkg::ST_RUN;
                else if (entry_end)
                    next_state = hpbc_pkg::ST_HALTED;
            hpbc_pkg::ST_HALTED:
                if (halt_release)
                    next_state = (mode_q == hpbc_pkg::MODE_DEEP_STOP)
                                 ? hpbc_pkg::ST_WARMUP
                                 : hpbc_pkg::ST_RUN;
            hpbc_pkg::ST_WARMUP:
                if (wu.done)
                    next_state = hpbc_pkg::ST_RUN;
        endcase
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            state <= hpbc_pkg::ST_RUN;
        else
            state <= next_state;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            exec_cnt <= '0;
        else if (state == hpbc_pkg::ST_ENTRY)
            exec_cnt <= exec_cnt + hpbc_pkg::EXEC_W'(1);
        else
            exec_cnt <= '0;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            mode_q <= hpbc_pkg::MODE_NONE;
        else if (state == hpbc_pkg::ST_RUN && halt_enter)
            mode_q <= halt_mode;
    end

    // -----------------------------------------------------------------
    // restart clock choice
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            restart_q <= 1'b0;
        else if (state == hpbc_pkg::ST_HALTED && halt_release)
            restart_q <= restart_slow;
    end

    always_comb
    begin
        wu.start = state == hpbc_pkg::ST_HALTED && halt_release
                   && mode_q == hpbc_pkg::MODE_DEEP_STOP;
        wu.sel   = warmup_sel;
        wu.slow  = restart_slow;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            low_speed_active <= 1'b0;
        else if (state == hpbc_pkg::ST_WARMUP && wu.done)
            low_speed_active <= restart_q;
        else if (state == hpbc_pkg::ST_RUN)
            low_speed_active <= run_slow;
    end

    // -----------------------------------------------------------------
    // pin buffer gating
    // -----------------------------------------------------------------
    always_comb
    begin
        unused_sel = drive_sel;
        light  = next_state == hpbc_pkg::ST_HALTED
                 && mode_q == hpbc_pkg::MODE_OSC_ONLY;
        deep   = (next_state == hpbc_pkg::ST_HALTED
                  || next_state == hpbc_pkg::ST_WARMUP)
                 && mode_q == hpbc_pkg::MODE_DEEP_STOP;
        cond_b = drive_ctrl;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            func_in_buf_en     <= 1'b1;
            func_out_buf_en    <= 1'b1;
            osc_in_buf_en      <= 1'b1;
            osc_out_drive_en   <= 1'b1;
            osc_out_force_high <= 1'b0;
        end
        else
        begin
            func_in_buf_en     <= !(light || deep) || cond_b;
            func_out_buf_en    <= !(light || deep) || cond_b;
            osc_in_buf_en      <= !deep;
            osc_out_drive_en   <= !deep;
            osc_out_force_high <= deep;
        end
    end

    // -----------------------------------------------------------------
    // status
    // -----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cpu_clock_run <= 1'b1;
            halted        <= 1'b0;
            warmup_busy   <= 1'b0;
        end
        else
        begin
            cpu_clock_run <= next_state == hpbc_pkg::ST_RUN;
            halted        <= next_state == hpbc_pkg::ST_HALTED;
            warmup_busy   <= next_state == hpbc_pkg::ST_WARMUP;
        end
    end

    // -----------------------------------------------------------------
    // checks
    // -----------------------------------------------------------------
    sequence entry_seq;
        state == hpbc_pkg::ST_RUN && halt_enter
        && halt_mode != hpbc_pkg::MODE_NONE;
    endsequence
    sequence quiet_six;
        !halt_release [*6];
    endsequence

    entry_length_a: assert property (@(posedge clock) disable iff (!arst_n)
        entry_seq ##1 quiet_six |=> halted)
        else $error("halt entry did not take six states");
    early_release_a: assert property (@(posedge clock) disable iff (!arst_n)
        (state == hpbc_pkg::ST_ENTRY && halt_release)
        |=> state == hpbc_pkg::ST_RUN && !warmup_busy)
        else $error("early release did not return to run");
    deep_warmup_a: assert property (@(posedge clock) disable iff (!arst_n)
        (state == hpbc_pkg::ST_HALTED && halt_release
         && mode_q == hpbc_pkg::MODE_DEEP_STOP)
        |=> warmup_busy && !cpu_clock_run)
        else $error("deep stop release skipped warm-up");
    resume_clock_a: assert property (@(posedge clock) disable iff (!arst_n)
        (state == hpbc_pkg::ST_WARMUP && wu.done)
        |=> low_speed_active == $past(restart_q) && cpu_clock_run)
        else $error("resume clock does not match restart choice");
    cond_b_keep_a: assert property (@(posedge clock) disable iff (!arst_n)
        ($past(cond_b) && halted) |-> func_in_buf_en && func_out_buf_en)
        else $error("condition B gated function buffers");
    cond_a_gate_a: assert property (@(posedge clock) disable iff (!arst_n)
        (!drive_ctrl && state == hpbc_pkg::ST_HALTED
         && mode_q != hpbc_pkg::MODE_CPU_ONLY && !halt_release)
        |=> !func_in_buf_en && !func_out_buf_en)
        else $error("condition A left function buffers on");
    osc_in_a: assert property (@(posedge clock) disable iff (!arst_n)
        (halted && $past(mode_q) == hpbc_pkg::MODE_OSC_ONLY)
        |-> osc_in_buf_en && osc_out_drive_en)
        else $error("oscillator buffers off in light halt");
    osc_out_high_a: assert property (@(posedge clock) disable iff (!arst_n)
        (halted && $past(mode_q) == hpbc_pkg::MODE_DEEP_STOP)
        |-> osc_out_force_high && !osc_in_buf_en)
        else $error("oscillator output not held high in deep stop");
endmodule : halt_pin_buffer_control
`default_nettype wire

// >>> hpbc_halt_model.sv
// halt controller model issuing halt entry, release and clock mode
`timescale 1ns/100ps
`default_nettype none
module hpbc_halt_model (
    // clock
    input  wire logic       clock,
    // halt requests
    output var  logic       halt_enter,
    output var  logic [1:0] halt_mode,
    output var  logic       halt_release,
    // running clock mode
    output var  logic       run_slow
);
    initial
    begin
        halt_enter   = 1'b0;
        halt_mode    = 2'h0;
        halt_release = 1'b0;
        run_slow     = 1'b0;
    end

    // one-cycle halt instruction start with its mode
    task automatic enter(input logic [1:0] mode);
        @(negedge clock);
        halt_enter = 1'b1;
        halt_mode  = mode;
        @(negedge clock);
        halt_enter = 1'b0;
        halt_mode  = ~mode;
    endtask : enter

    // one-cycle release request
    task automatic release_halt;
        @(negedge clock);
        halt_release = 1'b1;
        @(negedge clock);
        halt_release = 1'b0;
    endtask : release_halt

    // clock mode changed only while running
    task automatic set_clock(input logic slow);
        @(negedge clock);
        run_slow = slow;
    endtask : set_clock
endmodule : hpbc_halt_model
`default_nettype wire

// >>> halt_pin_buffer_control_test.sv
// self-checking bench for the halt pin buffer control block
`timescale 1ns/100ps
`default_nettype none
module halt_pin_buffer_control_test;
    localparam int HS = 1;
    localparam int LS = 2;
    localparam int EXP_S = 2;
    localparam int EXP_M = 3;
    localparam int EXP_L = 4;
    logic       clock = 1'b0;
    logic       arst_n = 1'b0;
    logic       halt_enter, halt_release, run_slow;
    logic [1:0] halt_mode;
    logic [1:0] warmup_sel = 2'h1;
    logic       restart_slow = 1'b0;
    logic       drive_ctrl = 1'b0;
    logic       drive_sel = 1'b0;
    logic       cpu_clock_run, low_speed_active, halted, warmup_busy;
    logic       func_in_buf_en, func_out_buf_en, osc_in_buf_en;
    logic       osc_out_drive_en, osc_out_force_high;
    int         errors = 0;
    int         n_checks = 0;
    // -----------------------------------------------------------------
    // clock, model and design
    // -----------------------------------------------------------------
    always #5 clock = ~clock;

    hpbc_halt_model i_hpbc_halt_model (
        .clock        (clock),
        .halt_enter   (halt_enter),
        .halt_mode    (halt_mode),
        .halt_release (halt_release),
        .run_slow     (run_slow)
    );

    halt_pin_buffer_control #(.HS_DIV(HS), .LS_DIV(LS), .EXP_SHORT(EXP_S),
        .EXP_MID(EXP_M), .EXP_LONG(EXP_L)) i_halt_pin_buffer_control (
        .clock (clock), .arst_n (arst_n), .halt_enter (halt_enter),
        .halt_mode (halt_mode), .halt_release (halt_release),
        .warmup_sel (warmup_sel), .restart_slow (restart_slow),
        .run_slow (run_slow), .drive_ctrl (drive_ctrl),
        .drive_sel (drive_sel), .cpu_clock_run (cpu_clock_run),
        .low_speed_active (low_speed_active), .halted (halted),
        .warmup_busy (warmup_busy), .func_in_buf_en (func_in_buf_en),
        .func_out_buf_en (func_out_buf_en), .osc_in_buf_en (osc_in_buf_en),
        .osc_out_drive_en (osc_out_drive_en),
        .osc_out_force_high (osc_out_force_high)
    );
    // -----------------------------------------------------------------
    // shared checks
    // -----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask : check

    function automatic logic [4:0] bufs;
        return {func_in_buf_en, func_out_buf_en, osc_in_buf_en,
                osc_out_drive_en, osc_out_force_high};
    endfunction : bufs

    task automatic enter_wait(input logic [1:0] mode);
        int k;
        i_hpbc_halt_model.enter(mode);
        for (k = 1; k < 20; k++)
        begin
            if (k == 1)
                check({31'h0, cpu_clock_run}, 32'h0, "clock stop");
            if (halted === 1'b1)
                break;
            @(negedge clock);
        end
        check(k, 7, "entry length");
    endtask : enter_wait

    task automatic leave_light;
        int k;
        i_hpbc_halt_model.release_halt();
        for (k = 0; k < 3 && cpu_clock_run !== 1'b1; k++)
            @(negedge clock);
        check({31'h0, cpu_clock_run}, 32'h1, "light resume");
        check({27'h0, bufs()}, 32'h1E, "buffers back on");
    endtask : leave_light
    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    task automatic t_reset;
        check({28'h0, cpu_clock_run, low_speed_active, halted, warmup_busy},
              32'h8, "reset status");
        check({27'h0, bufs()}, 32'h1E, "reset buffers");
    endtask : t_reset

    task automatic t_light(input logic cond, input logic dsel);
        drive_ctrl = cond;
        drive_sel  = dsel;
        enter_wait(2'h2);
        check({27'h0, bufs()}, {27'h0, cond, cond, 3'b110}, "light bufs");
        leave_light();
    endtask : t_light

    task automatic t_cpu_only;
        drive_ctrl = 1'b0;
        enter_wait(2'h3);
        check({27'h0, bufs()}, 32'h1E, "cpu halt bufs");
        leave_light();
    endtask : t_cpu_only

    task automatic t_deep(input logic [1:0] sel, input logic rslow);
        int k;
        int e;
        e = (sel == 2'h3) ? EXP_L : (sel == 2'h2) ? EXP_M : EXP_S;
        e = (1 << e) * (rslow ? LS : HS);
        i_hpbc_halt_model.set_clock(~rslow);
        warmup_sel   = sel;
        restart_slow = rslow;
        drive_ctrl   = 1'b0;
        enter_wait(2'h1);
        check({29'h0, func_in_buf_en, osc_in_buf_en, osc_out_force_high},
              32'h1, "stop bufs");
        i_hpbc_halt_model.release_halt();
        for (k = 0; k < 200 && cpu_clock_run !== 1'b1; k++)
        begin
            @(negedge clock);
            if (k == 0)
                check({31'h0, warmup_busy}, 32'h1, "warm-up busy");
        end
        check({31'h0, (k >= e && k <= e + 3)}, 32'h1, "warm-up length");
        check({31'h0, low_speed_active}, {31'h0, rslow}, "restart clock");
        check({27'h0, bufs()}, 32'h1E, "stop buffers back on");
    endtask : t_deep

    task automatic t_entry_release;
        int k;
        i_hpbc_halt_model.set_clock(1'b1);
        restart_slow = 1'b0;
        i_hpbc_halt_model.enter(2'h1);
        repeat (2) @(negedge clock);
        i_hpbc_halt_model.release_halt();
        for (k = 0; k < 6; k++)
        begin
            check({30'h0, halted, warmup_busy}, 32'h0, "no stop");
            @(negedge clock);
        end
        check({30'h0, cpu_clock_run, low_speed_active}, 32'h3, "mode kept");
    endtask : t_entry_release

    task automatic t_refused;
        i_hpbc_halt_model.enter(2'h0);
        @(negedge clock);
        check({31'h0, cpu_clock_run}, 32'h1, "no-halt code ignored");
        drive_ctrl = 1'b0;
        enter_wait(2'h2);
        i_hpbc_halt_model.enter(2'h1);
        @(negedge clock);
        check({27'h0, bufs()}, 32'h06, "enter while halted ignored");
        leave_light();
    endtask : t_refused
    // -----------------------------------------------------------------
    // run control
    // -----------------------------------------------------------------
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    initial
    begin
        repeat (20) @(negedge clock);
        arst_n = 1'b1;
        t_reset();
        for (int c = 0; c < 4; c++)
            t_light(c[1], c[0]);
        t_cpu_only();
        for (int s = 0; s < 8; s++)
            t_deep(s[1:0], s[2]);
        t_entry_release();
        t_refused();
        summarize();
    end

    initial
    begin
        repeat (20000) @(posedge clock);
        errors++;
        summarize();
    end
endmodule : halt_pin_buffer_control_test
`default_nettype wire
